/* tcs_cfg.svh */
/*
  Constants of the timer 0/1 count and tick source block: register offsets,
  field positions, reset values, mode codes and the prescale figure.
  Assumes it is included by bare name from the package and the design.
*/
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH

// Register byte addresses on the plain register port.
`define TCS_ADDR_RUN_CTRL    8'h88
`define TCS_ADDR_MODE        8'h89
`define TCS_ADDR_T0_LOW      8'h8A
`define TCS_ADDR_T1_LOW      8'h8B
`define TCS_ADDR_T0_HIGH     8'h8C
`define TCS_ADDR_T1_HIGH     8'h8D
`define TCS_ADDR_TICK_CTRL   8'h8E
`define TCS_ADDR_IRQ_STATUS  8'hA0
`define TCS_ADDR_IRQ_MASK    8'hA1

// Reset values.
`define TCS_RESET_BYTE       8'h00
`define TCS_RESET_PRESCALE   4'h0

// Tick source control fields.
`define TCS_TICK_PWM_SEL     6
`define TCS_TICK_T1_FAST     4
`define TCS_TICK_T0_FAST     3
`define TCS_TICK_CLK_OUT     1
`define TCS_TICK_RW_MASK     8'h5A

// Run control fields.
`define TCS_RUN_T1_FLAG      7
`define TCS_RUN_T1_RUN       6
`define TCS_RUN_T0_FLAG      5
`define TCS_RUN_T0_RUN       4
`define TCS_RUN_RW_MASK      8'hF0

// Mode register fields.
`define TCS_MODE_T1_GATE     7
`define TCS_MODE_T1_EXT      6
`define TCS_MODE_T1_M_HI     5
`define TCS_MODE_T1_M_LO     4
`define TCS_MODE_T0_GATE     3
`define TCS_MODE_T0_EXT      2
`define TCS_MODE_T0_M_HI     1
`define TCS_MODE_T0_M_LO     0

// Count width modes.
`define TCS_MODE_13BIT       2'h0
`define TCS_MODE_16BIT       2'h1
`define TCS_MODE_8RELOAD     2'h2
`define TCS_MODE_SPLIT       2'h3

// Interrupt status and mask bits.
`define TCS_IRQ_T0           0
`define TCS_IRQ_T1           1
`define TCS_IRQ_RESET        2'h0

// System clock divider of the slow tick.
`define TCS_PRESCALE_DEFAULT 12
`define TCS_PRESCALE_MAX     16

`endif

/* tcs_pkg.sv */
/*
  Types of the timer 0/1 count and tick source block.
  Assumes tcs_cfg.svh is on the include path.
*/
`include "tcs_cfg.svh"

package tcs_pkg;

  // Result of one counting step of a timer.
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic       ovf;
  } tcs_step_t;

  // Complete state of the block.
  typedef struct packed {
    logic [7:0] t0_low;
    logic [7:0] t0_high;
    logic [7:0] t1_low;
    logic [7:0] t1_high;
    logic [7:0] tick_ctrl;
    logic [7:0] run_ctrl;
    logic [7:0] mode;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [3:0] prescale;
    logic       t0_pin_q;
    logic       t1_pin_q;
    logic       pwm_tick;
    logic [7:0] rdata;
  } tcs_state_t;

endpackage

/* tcs_top.sv */
/*
  Count registers of timers 0 and 1, their tick source selection, the PWM
  tick source and the system clock output gate, with run, mode, flag and
  interrupt registers, all on a plain byte register port.
  Assumes all inputs are synchronous to clk and that the host issues one
  strobe per cycle with read data taken the cycle after a read strobe.
*/
// The strobed register port was decided locally.
// Contract
// - Timer 0 low count byte is a read/write register that resets to zero.
// - Timer 0 high count byte is a separate read/write register that resets to zero.
// - Timer 1 low count byte is a read/write register that resets to zero.
// - Timer 1 high count byte is a separate read/write register that resets to zero.
// - Timer 0 ticks on system clock divided by twelve when its fast bit is 0, else every clock.
// - Timer 1 ticks on system clock divided by twelve when its fast bit is 0, else every clock.
// - The PWM tick is the system clock when its select bit is 0, else timer 1 overflows.
// - The system clock goes out on its pin only while the output enable bit is 1, reset 0.
// - A timer counts only while its run bit is 1 and holds its count when it is cleared.
// - Overflow sets the timer flag, service start clears it, and software may set or clear it.
// - A two-bit mode picks 13-bit, 16-bit, 8-bit reload, or halt/split operation per timer.
// - With the counter select bit set a timer counts falling edges of its external pin.
`timescale 1ns/1ps
`include "tcs_cfg.svh"

module tcs_top #(
  parameter int PRESCALE = `TCS_PRESCALE_DEFAULT
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       t0_pin,
  input  wire logic       t1_pin,
  input  wire logic       t0_gate_pin,
  input  wire logic       t1_gate_pin,
  input  wire logic       timer0_service_ack,
  input  wire logic       timer1_service_ack,
  output logic            timer0_overflow_flag,
  output logic            timer1_overflow_flag,
  output logic            pwm_tick,
  output logic            sysclk_output_pin,
  output logic            irq
);

  // The prescale counter is four bits wide, so the divider must fit in it.
  generate
    if (PRESCALE < 2 || PRESCALE > `TCS_PRESCALE_MAX) begin : g_bad_prescale
      $error("tcs_top: PRESCALE must lie between 2 and 16");
    end
  endgenerate

  // Last divider count before it wraps; the slow tick fires while the divider holds it.
  localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE - 1);

  // Every register, the divider and the edge flops clear on reset.
  localparam tcs_pkg::tcs_state_t STATE_RESET = '{
    t0_low:     `TCS_RESET_BYTE,
    t0_high:    `TCS_RESET_BYTE,
    t1_low:     `TCS_RESET_BYTE,
    t1_high:    `TCS_RESET_BYTE,
    tick_ctrl:  `TCS_RESET_BYTE,
    run_ctrl:   `TCS_RESET_BYTE,
    mode:       `TCS_RESET_BYTE,
    irq_status: `TCS_IRQ_RESET,
    irq_mask:   `TCS_IRQ_RESET,
    prescale:   `TCS_RESET_PRESCALE,
    t0_pin_q:   1'b0,
    t1_pin_q:   1'b0,
    pwm_tick:   1'b0,
    rdata:      `TCS_RESET_BYTE
  };

  // Registered state and the value it takes at the next edge.
  tcs_pkg::tcs_state_t state;
  tcs_pkg::tcs_state_t next_state;

  // One counting step in modes 0 to 2; the split/halt code is left to the caller.
  function automatic tcs_pkg::tcs_step_t timer_step(
    input logic [7:0] low,
    input logic [7:0] high,
    input logic [1:0] mode,
    input logic       inc
  );
    tcs_pkg::tcs_step_t r;
    logic [13:0]        sum13;
    logic [16:0]        sum16;
    logic [8:0]         sum8;
    r.low  = low;
    r.high = high;
    r.ovf  = 1'b0;
    sum13  = {1'b0, high, low[4:0]} + 14'h0001;
    sum16  = {1'b0, high, low} + 17'h00001;
    sum8   = {1'b0, low} + 9'h001;
    // All three sums are formed up front; the mode picks the one that lands.
    if (inc) begin
      case (mode)
        `TCS_MODE_13BIT: begin
          // Upper three bits of the low byte are not part of the count.
          r.low  = {low[7:5], sum13[4:0]};
          r.high = sum13[12:5];
          r.ovf  = sum13[13];
        end
        `TCS_MODE_16BIT: begin
          r.low  = sum16[7:0];
          r.high = sum16[15:8];
          r.ovf  = sum16[16];
        end
        `TCS_MODE_8RELOAD: begin
          r.low = sum8[8] ? high : sum8[7:0];
          r.ovf = sum8[8];
        end
        default: begin
          r.ovf = 1'b0;
        end
      endcase
    end
    return r;
  endfunction

  // Flag update: software write first, then service clear, then overflow set.
  // Placing the set last keeps an overflow that meets a clear from being lost.
  function automatic logic flag_next(
    input logic cur,
    input logic sw_wr,
    input logic sw_val,
    input logic ack,
    input logic ovf
  );
    logic f;
    f = cur;
    if (sw_wr) begin
      f = sw_val;
    end
    if (ack) begin
      f = 1'b0;
    end
    if (ovf) begin
      f = 1'b1;
    end
    return f;
  endfunction

  // Tick sources and pin edges.
  logic               slow_tick;
  logic               t0_fall;
  logic               t1_fall;

  // Mode decode and increment enables.
  logic [1:0]         t0_mode;
  logic [1:0]         t1_mode;
  logic               t0_inc;
  logic               t1_inc;
  logic               th0_inc;
  logic               t0_split;

  // Split-mode high byte and the overflow events of both timers.
  logic [8:0]         th0_sum;
  logic               th0_ovf;
  logic               t0_ovf;
  logic               t1_ovf;
  logic               t1_flag_set;

  // Register port decode and the raw counting steps.
  logic               run_wr;
  tcs_pkg::tcs_step_t s0;
  tcs_pkg::tcs_step_t s1;

  // Next state: tick sources, counting, flags and register port.
  always_comb begin
    // Every field holds unless a rule below moves it.
    next_state = state;

    // Free-running divider makes the slow tick once every PRESCALE clocks.
    slow_tick = (state.prescale == PRESCALE_LAST);
    next_state.prescale = slow_tick ? `TCS_RESET_PRESCALE : state.prescale + 4'h1;

    // Inputs are synchronous, so one flop per pin is enough for the edge.
    next_state.t0_pin_q = t0_pin;
    next_state.t1_pin_q = t1_pin;
    t0_fall = state.t0_pin_q & ~t0_pin;
    t1_fall = state.t1_pin_q & ~t1_pin;

    // Mode fields of both timers and the split decode of timer 0.
    t0_mode  = state.mode[`TCS_MODE_T0_M_HI:`TCS_MODE_T0_M_LO];
    t1_mode  = state.mode[`TCS_MODE_T1_M_HI:`TCS_MODE_T1_M_LO];
    t0_split = (t0_mode == `TCS_MODE_SPLIT);

    // Increment enables: run bit, optional gate pin, then the tick source.
    t0_inc = state.run_ctrl[`TCS_RUN_T0_RUN]
           & (~state.mode[`TCS_MODE_T0_GATE] | t0_gate_pin)
           & (state.mode[`TCS_MODE_T0_EXT] ? t0_fall
              : (state.tick_ctrl[`TCS_TICK_T0_FAST] | slow_tick));
    t1_inc = state.run_ctrl[`TCS_RUN_T1_RUN]
           & (~state.mode[`TCS_MODE_T1_GATE] | t1_gate_pin)
           & (state.mode[`TCS_MODE_T1_EXT] ? t1_fall
              : (state.tick_ctrl[`TCS_TICK_T1_FAST] | slow_tick));

    // Split mode: the low byte runs as an 8-bit timer on timer 0 controls,
    // and the high byte as an 8-bit timer on timer 1's run bit and flag.
    s0 = timer_step(state.t0_low, state.t0_high,
                    t0_split ? `TCS_MODE_16BIT : t0_mode, t0_inc);
    th0_inc = t0_split & state.run_ctrl[`TCS_RUN_T1_RUN]
            & (state.tick_ctrl[`TCS_TICK_T0_FAST] | slow_tick);
    th0_sum = {1'b0, state.t0_high} + {8'h00, th0_inc};
    th0_ovf = th0_sum[8];
    if (t0_split) begin
      s0.low  = state.t0_low + {7'h00, t0_inc};
      s0.high = th0_sum[7:0];
      s0.ovf  = t0_inc & (state.t0_low == 8'hFF);
    end
    t0_ovf = s0.ovf;

    // Mode code 3 halts timer 1; the step function leaves it unchanged.
    s1 = timer_step(state.t1_low, state.t1_high, t1_mode, t1_inc);
    t1_ovf = s1.ovf;
    // While timer 0 is split its high byte owns the timer 1 flag.
    t1_flag_set = t0_split ? th0_ovf : t1_ovf;

    // Counting results; register writes further down may still override them.
    next_state.t0_low  = s0.low;
    next_state.t0_high = s0.high;
    next_state.t1_low  = s1.low;
    next_state.t1_high = s1.high;

    // Registered PWM tick: every clock, or one pulse per timer 1 overflow.
    next_state.pwm_tick = state.tick_ctrl[`TCS_TICK_PWM_SEL] ? t1_ovf : 1'b1;

    // The flags live in the run control byte; a write there sets or clears both.
    run_wr = wr & (addr == `TCS_ADDR_RUN_CTRL);
    next_state.run_ctrl[`TCS_RUN_T0_FLAG] = flag_next(
      state.run_ctrl[`TCS_RUN_T0_FLAG], run_wr, wdata[`TCS_RUN_T0_FLAG],
      timer0_service_ack, t0_ovf);
    next_state.run_ctrl[`TCS_RUN_T1_FLAG] = flag_next(
      state.run_ctrl[`TCS_RUN_T1_FLAG], run_wr, wdata[`TCS_RUN_T1_FLAG],
      timer1_service_ack, t1_flag_set);

    // Sticky interrupt status; a written one clears, a new event wins.
    if (wr && addr == `TCS_ADDR_IRQ_STATUS) begin
      next_state.irq_status = state.irq_status & ~wdata[`TCS_IRQ_T1:`TCS_IRQ_T0];
    end
    if (t0_ovf) begin
      next_state.irq_status[`TCS_IRQ_T0] = 1'b1;
    end
    if (t1_flag_set) begin
      next_state.irq_status[`TCS_IRQ_T1] = 1'b1;
    end

    // Register writes; count byte writes override the step just computed.
    if (wr) begin
      case (addr)
        `TCS_ADDR_T0_LOW: begin
          next_state.t0_low = wdata;
        end
        `TCS_ADDR_T0_HIGH: begin
          next_state.t0_high = wdata;
        end
        `TCS_ADDR_T1_LOW: begin
          next_state.t1_low = wdata;
        end
        `TCS_ADDR_T1_HIGH: begin
          next_state.t1_high = wdata;
        end
        `TCS_ADDR_TICK_CTRL: begin
          next_state.tick_ctrl = wdata & `TCS_TICK_RW_MASK;
        end
        `TCS_ADDR_RUN_CTRL: begin
          next_state.run_ctrl[`TCS_RUN_T0_RUN] = wdata[`TCS_RUN_T0_RUN];
          next_state.run_ctrl[`TCS_RUN_T1_RUN] = wdata[`TCS_RUN_T1_RUN];
        end
        `TCS_ADDR_MODE: begin
          next_state.mode = wdata;
        end
        `TCS_ADDR_IRQ_MASK: begin
          next_state.irq_mask = wdata[`TCS_IRQ_T1:`TCS_IRQ_T0];
        end
        default: begin
          next_state.mode = state.mode;
        end
      endcase
    end

    // Read data stand for the one cycle after the strobe; unmapped reads zero.
    next_state.rdata = `TCS_RESET_BYTE;
    if (rd) begin
      case (addr)
        `TCS_ADDR_T0_LOW: begin
          next_state.rdata = state.t0_low;
        end
        `TCS_ADDR_T0_HIGH: begin
          next_state.rdata = state.t0_high;
        end
        `TCS_ADDR_T1_LOW: begin
          next_state.rdata = state.t1_low;
        end
        `TCS_ADDR_T1_HIGH: begin
          next_state.rdata = state.t1_high;
        end
        `TCS_ADDR_TICK_CTRL: begin
          next_state.rdata = state.tick_ctrl;
        end
        `TCS_ADDR_RUN_CTRL: begin
          next_state.rdata = state.run_ctrl & `TCS_RUN_RW_MASK;
        end
        `TCS_ADDR_MODE: begin
          next_state.rdata = state.mode;
        end
        `TCS_ADDR_IRQ_STATUS: begin
          next_state.rdata = {6'h00, state.irq_status};
        end
        `TCS_ADDR_IRQ_MASK: begin
          next_state.rdata = {6'h00, state.irq_mask};
        end
        default: begin
          next_state.rdata = `TCS_RESET_BYTE;
        end
      endcase
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Outputs come straight from the state flops, apart from the irq reduction.
  assign rdata                = state.rdata;
  assign timer0_overflow_flag = state.run_ctrl[`TCS_RUN_T0_FLAG];
  assign timer1_overflow_flag = state.run_ctrl[`TCS_RUN_T1_FLAG];
  assign pwm_tick             = state.pwm_tick;
  assign irq                  = |(state.irq_status & state.irq_mask);

  // The clock itself cannot come from a flop, so it is gated by the enable
  // bit; the enable changes only on a rising edge, while clk is high, which
  // can shorten the first or last high phase on the pin.
  assign sysclk_output_pin = clk & state.tick_ctrl[`TCS_TICK_CLK_OUT];

endmodule

/* tcs_props.sv */
/*
  Port checker for the timer 0/1 count and tick source block.
  Assumes it is bound to tcs_top, rising-edge clk, synchronous rst.
*/
`timescale 1ns/1ps

module tcs_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       timer0_service_ack,
  input wire logic       timer1_service_ack,
  input wire logic       timer0_overflow_flag,
  input wire logic       timer1_overflow_flag,
  input wire logic       pwm_tick,
  input wire logic       sysclk_output_pin,
  input wire logic       irq
);
  // All checks share the system clock and its reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Read data stand only in the cycle after a read strobe.
  property p_rd_idle; !rd |=> rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmapped; rd && addr == 8'h90 |=> rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_tick_resv; rd && addr == 8'h8E |=> (rdata & 8'hA5) == 8'h00; endproperty
  a_tick_resv: assert property (p_tick_resv) else $error("tick control reserved");
  property p_run_resv; rd && addr == 8'h88 |=> rdata[3:0] == 4'h0; endproperty
  a_run_resv: assert property (p_run_resv) else $error("run control reserved");
  property p_irq_rd; rd && addr == 8'hA0 |=> rdata[7:2] == 6'h00; endproperty
  a_irq_rd: assert property (p_irq_rd) else $error("status reserved");
  // A service pulse in the same cycle clears the flag after the write, so it is left out.
  property p_flag0_set;
    wr && addr == 8'h88 && wdata[5] && !timer0_service_ack |=> timer0_overflow_flag;
  endproperty
  a_flag0_set: assert property (p_flag0_set) else $error("flag 0 not set");
  property p_flag1_set;
    wr && addr == 8'h88 && wdata[7] && !timer1_service_ack |=> timer1_overflow_flag;
  endproperty
  a_flag1_set: assert property (p_flag1_set) else $error("flag 1 not set");
  property p_irq_mask; wr && addr == 8'hA1 && wdata[1:0] == 2'h0 |=> !irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
  // The select takes one edge, the registered tick one more.
  property p_pwm_sys; wr && addr == 8'h8E && !wdata[6] |=> ##1 pwm_tick; endproperty
  a_pwm_sys: assert property (p_pwm_sys) else $error("pwm tick not steady");
  // Sampled at the falling edge, so the gated clock is seen high when enabled.
  property p_clk_out;
    @(negedge clk) wr && addr == 8'h8E |=> sysclk_output_pin == $past(wdata[1]);
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock output gate");
endmodule

bind tcs_top tcs_props i_props (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .timer0_service_ack(timer0_service_ack), .timer1_service_ack(timer1_service_ack),
  .timer0_overflow_flag(timer0_overflow_flag), .timer1_overflow_flag(timer1_overflow_flag),
  .pwm_tick(pwm_tick), .sysclk_output_pin(sysclk_output_pin), .irq(irq)
);

/* timer01_count_and_clock_select_bench.sv */
/*
  Self-checking bench of the timer 0/1 count and tick source block.
  Assumes tcs_top with its default prescale of twelve and the bound checker.
*/
`timescale 1ns/1ps

module timer01_count_and_clock_select_bench;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [1:0] pin = 2'h3;
  logic [1:0] ack = 2'h0;
  logic       gate = 1'b0;
  logic [7:0] rdata;
  logic [1:0] flag;
  logic       pwm_tick;
  logic       clk_out;
  logic       irq;
  logic [15:0] v;
  logic [7:0] a;
  logic [7:0] regs [10] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'hA0, 8'hA1, 8'h90};
  int         bad_count = 0;
  int         checked = 0;

  // A 40 ns period gives the 25 MHz system clock.
  always #20 clk = ~clk;

  tcs_top i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .t0_pin(pin[0]), .t1_pin(pin[1]), .t0_gate_pin(gate), .t1_gate_pin(1'b0),
    .timer0_service_ack(ack[0]), .timer1_service_ack(ack[1]), .timer0_overflow_flag(flag[0]),
    .timer1_overflow_flag(flag[1]), .pwm_tick(pwm_tick), .sysclk_output_pin(clk_out),
    .irq(irq));

  // Byte and bit comparisons use case equality so an unknown never matches.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe; returns in the time step of the taking edge.
  task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= ad;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data are looked at only in the cycle after the strobe.
  task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= ad;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk8(rdata, e);
  endtask

  // One counting step of a timer in the given width mode.
  function automatic logic [15:0] nxt(input int t, input logic [1:0] m, input logic [15:0] x);
    logic [12:0] c;
    c = {x[15:8], x[4:0]} + 13'h0001;
    case (m)
      2'h0: return {c[12:5], x[7:5], c[4:0]};
      2'h1: return x + 16'h0001;
      2'h2: return (x[7:0] == 8'hFF) ? {x[15:8], x[15:8]} : x + 16'h0001;
      default: return (t == 1) ? x : {x[15:8], x[7:0] + 8'h01};
    endcase
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A hang counts as a mismatch.
  initial begin
    #1000000;
    bad_count++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'hD91B));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[k]) rchk(regs[k], 8'h00);
    for (int k = 0; k < 4; k++) begin
      a = 8'($urandom);
      wreg(8'(8'h8A + k), a);
      rchk(8'(8'h8A + k), a);
    end
    a = 8'($urandom);
    wreg(8'h8E, a);
    rchk(8'h8E, a & 8'h5A);
    // Sixty slow edges hold exactly five ticks whatever the divider phase.
    for (int f = 1; f >= 0; f--) begin
      wreg(8'h8E, f ? 8'h18 : 8'h00);
      for (int t = 0; t < 2; t++) begin
        for (int m = 0; m < 4; m++) begin
          wreg(8'h89, {2'h0, m[1:0], 2'h0, m[1:0]});
          v = 16'($urandom);
          wreg(8'(8'h8A + t), v[7:0]);
          wreg(8'(8'h8C + t), v[15:8]);
          wreg(8'h10 << (2 * t), 8'h00);
          wreg(8'h88, 8'h10 << (2 * t));
          repeat (f ? 0 : 58) @(posedge clk);
          wreg(8'h88, 8'h00);
          repeat (f ? 2 : 5) v = nxt(t, m[1:0], v);
          rchk(8'(8'h8A + t), v[7:0]);
          rchk(8'(8'h8C + t), v[15:8]);
        end
      end
    end
    for (int t = 0; t < 2; t++) begin
      wreg(8'h89, t ? 8'h50 : 8'h05);
      wreg(8'(8'h8A + t), 8'h00);
      wreg(8'h88, 8'h10 << (2 * t));
      repeat (3) begin
        @(posedge clk);
        pin[t] <= 1'b0;
        @(posedge clk);
        pin[t] <= 1'b1;
      end
      wreg(8'h88, 8'h00);
      rchk(8'(8'h8A + t), 8'h03);
    end
    // Overflow two edges after the run bit lands; the timer keeps running.
    for (int t = 0; t < 2; t++) begin
      wreg(8'h88, 8'h00);
      wreg(8'hA0, 8'h03);
      wreg(8'hA1, 8'h03);
      wreg(8'h89, 8'h11);
      wreg(8'h8E, t ? 8'h50 : 8'h08);
      wreg(8'(8'h8C + t), 8'hFF);
      wreg(8'(8'h8A + t), 8'hFE);
      wreg(8'h88, 8'h10 << (2 * t));
      repeat (2) @(posedge clk);
      #1 chk1(flag[t], 1'b1);
      chk1(irq, 1'b1);
      // With timer 1 overflows selected the registered PWM tick rises at the same edge as the flag; on the clock select it stays high.
      chk1(pwm_tick, 1'b1);
      @(posedge clk);
      #1 chk1(pwm_tick, t == 0);
      rchk(8'hA0, 8'h01 << t);
      wreg(8'hA1, 8'h00);
      #1 chk1(irq, 1'b0);
      wreg(8'hA1, 8'h03);
      #1 chk1(irq, 1'b1);
      @(posedge clk);
      ack[t] <= 1'b1;
      @(posedge clk);
      ack[t] <= 1'b0;
      #1 chk1(flag[t], 1'b0);
      wreg(8'hA0, 8'h01 << t);
      #1 chk1(irq, 1'b0);
      wreg(8'h88, 8'h20 << (2 * t));
      #1 chk1(flag[t], 1'b1);
    end
    // Split timer 0 with its gate bit: the low byte needs the gate pin high,
    // the high byte runs on timer 1's run bit and timer 0's tick without the gate, two fast edges each pass.
    wreg(8'h8E, 8'h18);
    wreg(8'h89, 8'h0B);
    for (int g = 0; g < 2; g++) begin
      wreg(8'h8A, 8'h00);
      gate <= g[0];
      wreg(8'h8C, 8'h00);
      wreg(8'h88, 8'h50);
      wreg(8'h88, 8'h00);
      rchk(8'h8A, {6'h00, g[0], 1'b0});
      rchk(8'h8C, 8'h02);
    end
    wreg(8'h8E, 8'h02);
    #1 chk1(clk_out, 1'b1);
    wreg(8'h8E, 8'h00);
    #1 chk1(clk_out, 1'b0);
    give_verdict();
  end
endmodule
